// ### verilog/pcd_pkg.sv
// Constants, field layouts and carrier types for the per-port cable
// diagnostic and negotiation control block.
// Assumes an APB master on the core clock and two copper PHY ports.
//
// Summary of operation
// [R1] Result code: normal, open, short, failed
// [R2] Start bit launches test, self-clears when done
// [R3] Software polls start bit for zero first
// [R4] Fault distance bit 8 in diag bit 0
// [R5] Fault distance low byte, read-only, reset zero
// [R6] Loopback bit loops line receive to transmit
// [R7] Software leaves reserved bit 2 at zero
// [R8] Bit 7 enables negotiation, else bits 6,5
// [R9] Negotiation off: bit 6 picks 100 or 10
// [R10] Bit 5 forces duplex when off or failed
// [R11] Results held until next launch or reset
package pcd_pkg;
   // Register indices; byte address is four times the index
   localparam logic [1:0][7:0] IDX_DIAG = {8'h2a, 8'h1a};
   localparam logic [1:0][7:0] IDX_DIST = {8'h2b, 8'h1b};
   localparam logic [1:0][7:0] IDX_NEG = {8'h2c, 8'h1c};
   localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
   // Diagnostic control field positions
   localparam int DIAG_RES_LO = 5;
   localparam int DIAG_START = 4;
   localparam int DIAG_LOOP = 1;
   localparam int DIAG_CNT8 = 0;
   // Negotiation control field positions
   localparam int NEG_AN_EN = 7;
   localparam int NEG_SPEED = 6;
   localparam int NEG_DPX = 5;
   // Reset values
   localparam logic [7:0] DIST_RST = 8'h00;
   localparam logic [7:0] NEG_RST = 8'hff;
   localparam logic [3:0] MASK_RST = 4'h0;
   // Result codes
   localparam logic [1:0] RES_NORMAL = 2'h0;
   localparam logic [1:0] RES_OPEN = 2'h1;
   localparam logic [1:0] RES_SHORT = 2'h2;
   localparam logic [1:0] RES_FAIL = 2'h3;
   // Interrupt status bit positions
   localparam int IRQ_W = 4;
   localparam int IRQ_TEST = 0;   // Plus port number
   localparam int IRQ_ANFAIL = 2; // Plus port number
   // Timing
   localparam int CLK_MHZ = 25;
   localparam int TEST_TIMEOUT_US = 1000;
   localparam int TEST_TIMEOUT_CYC = TEST_TIMEOUT_US * CLK_MHZ;
   // Line-side status from one PHY
   typedef struct packed {
      logic test_done;      // One-cycle pulse from the tester
      logic [1:0] result;   // Outcome code
      logic [8:0] count;    // Distance count
      logic an_done;        // Negotiation complete
      logic an_failed;      // Negotiation failed
      logic an_spd100;      // Negotiated 100 Mbit
      logic an_full;        // Negotiated full duplex
   } pcd_line_t;
   // Controls toward one PHY
   typedef struct packed {
      logic test_start;     // One-cycle launch pulse
      logic loopback;       // Remote loopback
      logic an_en;          // Negotiation on
      logic spd100;         // Resolved speed
      logic full;           // Resolved duplex
   } pcd_phy_t;
   // Diagnostic state seen by software
   typedef struct packed {
      logic busy;
      logic [1:0] result;
      logic [8:0] count;
   } pcd_diag_t;
endpackage : pcd_pkg

// ### verilog/pcd_port_diag.sv
// Cable test sequencer for one port.
// Assumes the tester answers with a done pulse; a silent tester is
// timed out and reported as a failed test.
`timescale 1ns/1ns
module pcd_port_diag #(
   parameter logic [19:0] TIMEOUT = 20'(pcd_pkg::TEST_TIMEOUT_CYC)
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic launch,
   input wire pcd_pkg::pcd_line_t line,
   output pcd_pkg::pcd_diag_t diag,
   output logic start_pulse,
   output logic done_evt
);
   typedef enum logic {PCD_IDLE, PCD_RUN} pcd_state_t;
   pcd_state_t state; // Sequencer state
   logic [19:0] wait_cnt; // Cycles spent waiting on the tester
   logic finish; // Test ends this cycle
   logic tout; // Tester stayed silent too long
   logic [1:0] held_res; // Outcome of the last finished test
   logic [8:0] held_cnt; // Distance of the last finished test

   assign tout = (wait_cnt == TIMEOUT - 20'h0_0001);
   assign finish = (state == PCD_RUN) && (line.test_done || tout);

   // State and timeout counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= PCD_IDLE;
         wait_cnt <= 20'h0_0000;
      end else begin
         case (state)
            PCD_IDLE: begin
               wait_cnt <= 20'h0_0000;
               if (launch) begin
                  state <= PCD_RUN; // R2
               end
            end
            PCD_RUN: begin
               wait_cnt <= wait_cnt + 20'h0_0001;
               if (finish) begin
                  state <= PCD_IDLE; // R2
               end
            end
            default: state <= PCD_IDLE;
         endcase
      end
   end

   // Results: cleared at launch, loaded at the end, else held
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         held_res <= pcd_pkg::RES_NORMAL;
         held_cnt <= 9'h000;
      end else if (state == PCD_IDLE && launch) begin
         held_res <= pcd_pkg::RES_NORMAL; // R11
         held_cnt <= 9'h000;
      end else if (finish) begin
         // Timeout wins so a late pulse cannot report success
         held_res <= tout ? pcd_pkg::RES_FAIL : line.result; // R1
         held_cnt <= tout ? 9'h000 : line.count; // R4 R5
      end
   end

   // Launch and completion pulses
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_pulse <= 1'b0;
         done_evt <= 1'b0;
      end else begin
         start_pulse <= (state == PCD_IDLE) && launch;
         done_evt <= finish;
      end
   end

   // Start bit reads one while running
   assign diag = '{busy: (state == PCD_RUN), // R2
      result: held_res, count: held_cnt};

   launch_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
      (state == PCD_IDLE && launch) |=> diag.busy && start_pulse) // R2
      else $error("launch did not set busy");
   done_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
      (diag.busy && line.test_done && !tout) |=> !diag.busy
      && diag.result == $past(line.result)) // R2
      else $error("busy not cleared on done");
   result_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!diag.busy && !launch) |=> $stable(diag.result)
      && $stable(diag.count)) // R11
      else $error("result changed while idle");
   tout_fail_a: assert property (@(posedge clk) disable iff (!arst_n)
      (diag.busy && tout) |=> diag.result == pcd_pkg::RES_FAIL) // R1
      else $error("timeout not reported as failure");
endmodule : pcd_port_diag

// ### verilog/pcd_top.sv
// APB register bank for two copper ports: cable test, remote
// loopback and negotiation mode, plus a maskable interrupt.
// Assumes APB on CLOCK and PHY status synchronous to CLOCK.
`timescale 1ns/1ns
module pcd_top #(
   parameter int TEST_TIMEOUT_CYC = pcd_pkg::TEST_TIMEOUT_CYC
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic IRQ,
   input wire pcd_pkg::pcd_line_t [1:0] LINE_IN,
   output pcd_pkg::pcd_phy_t [1:0] PHY_OUT
);
   // Bus phase decode
   logic setup; // First cycle of a transfer
   logic access; // Access cycle, always completed at once
   logic wr; // Write takes effect this edge
   logic aligned; // Word aligned and inside the window
   logic [7:0] idx; // Register index from the byte address
   logic mapped; // Address hits a register
   logic [7:0] rd_byte; // Read data before the flop

   // Register hits, per port and shared
   logic [1:0] hit_diag;
   logic [1:0] hit_dist;
   logic [1:0] hit_neg;
   logic hit_stat;
   logic hit_mask;

   // Software-visible state and event tracking
   logic [1:0] loopback; // Remote loopback bits
   logic [1:0][7:0] neg; // Negotiation control bytes
   logic [pcd_pkg::IRQ_W-1:0] irq_stat; // Sticky events
   logic [pcd_pkg::IRQ_W-1:0] irq_mask; // Enables
   logic [pcd_pkg::IRQ_W-1:0] irq_set; // Events this cycle
   logic [1:0] an_fail_d; // Previous failure level

   // Per-port diagnostic links
   logic [1:0] launch;
   logic [1:0] start_pulse;
   logic [1:0] done_evt;
   pcd_pkg::pcd_diag_t [1:0] diag;

   assign idx = PADDR[9:2];
   assign aligned = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);
   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE;
   assign wr = access && PWRITE;

   // Address decode per port
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         hit_diag[p] = aligned && (idx == pcd_pkg::IDX_DIAG[p]);
         hit_dist[p] = aligned && (idx == pcd_pkg::IDX_DIST[p]);
         hit_neg[p] = aligned && (idx == pcd_pkg::IDX_NEG[p]);
      end
   end
   assign hit_stat = aligned && (idx == pcd_pkg::IDX_IRQ_STAT);
   assign hit_mask = aligned && (idx == pcd_pkg::IDX_IRQ_MASK);
   assign mapped = (|hit_diag) || (|hit_dist) || (|hit_neg)
      || hit_stat || hit_mask;

   // Zero wait states; unmapped addresses answer with an error
   // Every access completes in one cycle, so PREADY never stalls;
   // a slow register would need a wait state added here.
   assign PREADY = 1'b1;
   assign PSLVERR = access && !mapped;

   // Launch only from a one in the start position
   always_comb begin
      for (int p = 0; p < 2; p++) begin
         launch[p] = wr && hit_diag[p] && PWDATA[pcd_pkg::DIAG_START];
      end
   end

   // Loopback bits; reserved, result and count bits ignore writes
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         loopback <= 2'h0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (wr && hit_diag[p]) begin
               loopback[p] <= PWDATA[pcd_pkg::DIAG_LOOP];
            end
         end
      end
   end

   // Negotiation control bytes, plain read/write
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         neg <= {pcd_pkg::NEG_RST, pcd_pkg::NEG_RST};
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (wr && hit_neg[p]) begin
               neg[p] <= PWDATA[7:0];
            end
         end
      end
   end

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_byte = 8'h00;
      for (int p = 0; p < 2; p++) begin
         if (hit_diag[p]) begin
            rd_byte[pcd_pkg::DIAG_RES_LO +: 2] = diag[p].result; // R1
            rd_byte[pcd_pkg::DIAG_START] = diag[p].busy; // R2
            rd_byte[pcd_pkg::DIAG_LOOP] = loopback[p];
            rd_byte[pcd_pkg::DIAG_CNT8] = diag[p].count[8]; // R4
         end
         if (hit_dist[p]) begin
            rd_byte = diag[p].count[7:0]; // R5
         end
         if (hit_neg[p]) begin
            rd_byte = neg[p];
         end
      end
      if (hit_stat) begin
         rd_byte = {4'h0, irq_stat};
      end
      if (hit_mask) begin
         rd_byte = {4'h0, irq_mask};
      end
   end

   // Read data captured in the setup cycle, stable through access
   // One flop stage buys a read value that cannot move under the
   // master while the access phase lasts
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         PRDATA <= {24'h00_0000, rd_byte};
      end
   end

   // One sequencer per port
   // Each port runs its own test, so both cables can be measured at once
   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         pcd_port_diag #(
            .TIMEOUT(20'(TEST_TIMEOUT_CYC))
         ) u_diag (
            .clk(CLOCK),
            .arst_n(ARST_N),
            .launch(launch[p]),
            .line(LINE_IN[p]),
            .diag(diag[p]),
            .start_pulse(start_pulse[p]),
            .done_evt(done_evt[p])
         );
      end
   endgenerate

   // Failure edge detect for negotiation events
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         an_fail_d <= 2'h0;
      end else begin
         an_fail_d <= {LINE_IN[1].an_failed, LINE_IN[0].an_failed};
      end
   end

   // Events: test completion and negotiation failure per port
   // Only the rising edge of a failure counts, so a link that stays
   // failed raises one event rather than one per cycle
   always_comb begin
      irq_set = '0;
      for (int p = 0; p < 2; p++) begin
         irq_set[pcd_pkg::IRQ_TEST + p] = done_evt[p];
         irq_set[pcd_pkg::IRQ_ANFAIL + p] =
            LINE_IN[p].an_failed && !an_fail_d[p];
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   // Software can never lose an event that it has not yet seen,
   // even when its clear meets a new event in the same cycle
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_stat <= '0;
      end else if (wr && hit_stat) begin
         irq_stat <= (irq_stat & ~PWDATA[pcd_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat <= irq_stat | irq_set;
      end
   end

   // Mask register
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_mask <= pcd_pkg::MASK_RST;
      end else if (wr && hit_mask) begin
         irq_mask <= PWDATA[pcd_pkg::IRQ_W-1:0];
      end
   end

   // Level interrupt, straight from state
   assign IRQ = |(irq_stat & irq_mask);

   // PHY controls, registered so the line sees clean levels
   // Costs one cycle after a register write, but keeps decode
   // glitches away from the line side
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PHY_OUT <= '0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            PHY_OUT[p].test_start <= start_pulse[p];
            PHY_OUT[p].loopback <= loopback[p]; // R6
            PHY_OUT[p].an_en <= neg[p][pcd_pkg::NEG_AN_EN]; // R8
            // Forced speed only when negotiation is off
            if (!neg[p][pcd_pkg::NEG_AN_EN]) begin
               PHY_OUT[p].spd100 <= neg[p][pcd_pkg::NEG_SPEED]; // R9
            end else begin
               PHY_OUT[p].spd100 <= LINE_IN[p].an_spd100;
            end
            // Forced duplex also covers a failed negotiation
            if (!neg[p][pcd_pkg::NEG_AN_EN] || LINE_IN[p].an_failed)
            begin
               PHY_OUT[p].full <= neg[p][pcd_pkg::NEG_DPX]; // R10
            end else begin
               PHY_OUT[p].full <= LINE_IN[p].an_full;
            end
         end
      end
   end

   // Checks per port
   generate
      for (genvar p = 0; p < 2; p++) begin : g_chk
         loop_out_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            ##1 PHY_OUT[p].loopback == $past(loopback[p])) // R6
            else $error("loopback not driven to PHY");
         an_mode_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            (wr && hit_neg[p]) |=> ##1
            PHY_OUT[p].an_en == $past(PWDATA[7], 2)) // R8
            else $error("negotiation enable not applied");
         force_speed_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            !neg[p][7] |=> PHY_OUT[p].spd100 == $past(neg[p][6])) // R9
            else $error("forced speed wrong");
         force_dpx_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            (!neg[p][7] || LINE_IN[p].an_failed)
            |=> PHY_OUT[p].full == $past(neg[p][5])) // R10
            else $error("forced duplex wrong");
         count_hi_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            (setup && !PWRITE && hit_diag[p])
            |=> PRDATA[0] == $past(diag[p].count[8])
            && PRDATA[2] == 1'b0) // R4
            else $error("distance bit 8 misplaced");
         count_lo_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            (setup && !PWRITE && hit_dist[p])
            |=> PRDATA == {24'h00_0000, $past(diag[p].count[7:0])}) // R5
            else $error("distance low byte wrong");
         result_rd_a: assert property (@(posedge CLOCK)
            disable iff (!ARST_N)
            (setup && !PWRITE && hit_diag[p])
            |=> PRDATA[6:5] == $past(diag[p].result)
            && PRDATA[4] == $past(diag[p].busy)) // R1
            else $error("result code misplaced");
         // Launch pulse reaches the line two edges after the write
         start_out_a: assert property (@(posedge CLOCK) // R2
            disable iff (!ARST_N)
            (launch[p] && !diag[p].busy)
            |=> ##1 PHY_OUT[p].test_start)
            else $error("test start not sent to PHY");
         loop_keep_a: assert property (@(posedge CLOCK) // R6
            disable iff (!ARST_N)
            !(wr && hit_diag[p]) |=> $stable(loopback[p]))
            else $error("loopback changed without a write");
      end
   endgenerate

   irq_set_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (|irq_set) |=> (irq_stat & $past(irq_set)) == $past(irq_set))
      else $error("event lost against clear");

   // With no new event in the same cycle, every bit written as one must be gone
   stat_clear_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (wr && hit_stat && irq_set == '0)
      |=> (irq_stat & $past(PWDATA[pcd_pkg::IRQ_W-1:0])) == '0)
      else $error("status bit not cleared");

   // Unmasking a pending event raises the interrupt at once
   irq_level_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (wr && hit_mask && |(irq_stat & PWDATA[pcd_pkg::IRQ_W-1:0]))
      |=> IRQ)
      else $error("interrupt level wrong");

   // A refused write must leave the loopback, negotiation and mask registers alone
   bad_wr_a: assert property (@(posedge CLOCK) disable iff (!ARST_N)
      (wr && !mapped) |=> $stable(neg) && $stable(loopback)
      && $stable(irq_mask))
      else $error("unmapped write changed a register");
endmodule : pcd_top

// ### dv/pcd_line_model.sv
// Behavioural copper line for one port: cable tester and link status.
// Assumes the block pulses test_start once per launch.
`timescale 1ns/1ns
module pcd_line_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire pcd_pkg::pcd_phy_t phy,
   input wire logic [7:0] delay,   // Cycles to answer, 0 = silent
   input wire logic [1:0] result,  // Outcome to report
   input wire logic [8:0] count,   // Distance to report
   input wire logic [3:0] an,      // Done, failed, speed, duplex
   output pcd_pkg::pcd_line_t line
);
   logic [7:0] left;  // Cycles until the answer
   logic busy;        // Tester running
   logic done;        // Answer cycle

   // Tester run length; a zero delay never answers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         left <= 8'h00;
      end else if (phy.test_start) begin
         busy <= (delay != 8'h00);
         left <= delay;
      end else if (busy) begin
         left <= left - 8'h01;
         busy <= (left != 8'h01);
      end
   end

   assign done = busy && (left == 8'h01);

   // Outcome is only valid with the pulse; otherwise inverted junk,
   // so a block that samples late sees the wrong value
   always_comb begin
      line.test_done = done;
      line.result = done ? result : ~result;
      line.count = done ? count : ~count;
      {line.an_done, line.an_failed, line.an_spd100, line.an_full} = an;
   end
endmodule : pcd_line_model

// ### dv/tb.sv
// Self-checking bench for the two-port cable test and negotiation bank.
// Assumes an APB master here and one line model per port.
`timescale 1ns/1ns
module tb;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   pcd_pkg::pcd_line_t [1:0] line;
   pcd_pkg::pcd_phy_t [1:0] phy;
   logic [7:0] dly [2] = '{8'h00, 8'h00};  // Tester delays
   logic [1:0] res [2] = '{2'h0, 2'h0};    // Tester outcomes
   logic [8:0] cnt [2] = '{9'h000, 9'h000}; // Tester distances
   logic [3:0] an [2] = '{4'h0, 4'h0};     // Link status
   int n_mismatch = 0;
   int check_count = 0;
   int cycles = 0;

   // Short tester timeout keeps the failed-test case quick
   pcd_top #(.TEST_TIMEOUT_CYC(20)) u_pcd_top (
      .CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .LINE_IN(line),
      .PHY_OUT(phy));

   // One line model per port
   for (genvar g = 0; g < 2; g++) begin : g_line
      pcd_line_model u_pcd_line_model (
         .clk(clock), .arst_n(arst_n), .phy(phy[g]), .delay(dly[g]),
         .result(res[g]), .count(cnt[g]), .an(an[g]), .line(line[g]));
   end

   // 25 MHz core clock
   always #20 clock = ~clock;

   // Hang guard, well above the whole run
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk

   // Byte address from a register index
   function automatic logic [11:0] ba(input logic [7:0] idx);
      ba = {2'b00, idx, 2'b00};
   endfunction : ba

   // One APB transfer; a spare cycle after release avoids re-driving
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [7:0] d, output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] v;
      logic e;
      apb(1'b1, a, d, v, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      logic e;
      apb(1'b0, a, 8'h00, v, e);
   endtask : rd

   // Reset values and an unmapped address
   task automatic t_reset();
      logic [31:0] v;
      logic e;
      for (int p = 0; p < 2; p++) begin
         rd(ba(pcd_pkg::IDX_DIAG[p]), v);
         chk(v, 32'h0000_0000);
         rd(ba(pcd_pkg::IDX_DIST[p]), v);
         chk(v, 32'h0000_0000);
         rd(ba(pcd_pkg::IDX_NEG[p]), v);
         chk(v, 32'h0000_00ff);
         // Negotiation on; idle link reports 10 Mbit, half duplex
         chk(32'(phy[p]), 32'h0000_0004);
      end
      apb(1'b0, 12'h004, 8'h00, v, e);
      chk({v[30:0], e}, 32'h0000_0001);
      apb(1'b1, 12'h006, 8'hff, v, e);
      chk(32'(e), 32'h0000_0001);
      $display("test reset done");
   endtask : t_reset

   // Loopback bit reaches only its own port
   task automatic t_loop();
      logic [31:0] v;
      for (int p = 0; p < 2; p++) begin
         wr(ba(pcd_pkg::IDX_DIAG[p]), 8'h02);
         @(posedge clock);
         chk(32'(phy[p].loopback), 32'h0000_0001);
         chk(32'(phy[1 - p].loopback), 32'h0000_0000);
         rd(ba(pcd_pkg::IDX_DIAG[p]), v);
         chk(v, 32'h0000_0002);
         wr(ba(pcd_pkg::IDX_DIAG[p]), 8'h00);
      end
      $display("test loopback done");
   endtask : t_loop

   // Launch, poll for completion, then check the held outcome
   task automatic t_cable(input int p, input logic [7:0] d,
      input logic [1:0] r, input logic [8:0] c, input logic [1:0] xr,
      input logic [8:0] xc);
      logic [31:0] v;
      int n;
      n = 0;
      dly[p] <= d;
      res[p] <= r;
      cnt[p] <= c;
      wr(ba(pcd_pkg::IDX_DIAG[p]), 8'h10);
      rd(ba(pcd_pkg::IDX_DIAG[p]), v);
      chk(32'(v[4]), 32'h0000_0001);
      while (v[4] !== 1'b0 && n < 40) begin
         rd(ba(pcd_pkg::IDX_DIAG[p]), v);
         n++;
      end
      chk(32'(v[4]), 32'h0000_0000);
      chk(32'(v[6:5]), 32'(xr));
      chk(32'(v[0]), 32'(xc[8]));
      rd(ba(pcd_pkg::IDX_DIST[p]), v);
      chk(v, 32'(xc[7:0]));
      // Writes to the read-only fields must not disturb them
      wr(ba(pcd_pkg::IDX_DIAG[p]), 8'h61);
      repeat (4) @(posedge clock);
      rd(ba(pcd_pkg::IDX_DIAG[p]), v);
      chk(32'(v[6:0]), 32'({xr, 4'h0, xc[8]}));
      rd(ba(pcd_pkg::IDX_DIST[p]), v);
      chk(v, 32'(xc[7:0]));
      $display("test cable port %0d done", p + 1);
   endtask : t_cable

   // Forced and negotiated speed and duplex, incl. failed negotiation
   task automatic t_neg();
      logic [7:0] nv [4] = '{8'h40, 8'h20, 8'hc0, 8'ha0};
      logic [3:0] av [4] = '{4'h9, 4'ha, 4'h9, 4'h6};
      logic [2:0] xv [4] = '{3'h2, 3'h1, 3'h5, 3'h7};
      logic [31:0] v;
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 4; i++) begin
            an[p] <= av[i];
            wr(ba(pcd_pkg::IDX_NEG[p]), nv[i]);
            @(posedge clock);
            chk(32'(phy[p][2:0]), 32'(xv[i]));
            rd(ba(pcd_pkg::IDX_NEG[p]), v);
            chk(v, 32'(nv[i]));
         end
      end
      $display("test negotiation done");
   endtask : t_neg

   // Sticky status, mask and write-one-to-clear
   task automatic t_irq();
      logic [31:0] v;
      rd(ba(pcd_pkg::IDX_IRQ_STAT), v);
      chk(v, 32'h0000_000f);
      chk(32'(irq), 32'h0000_0000);
      wr(ba(pcd_pkg::IDX_IRQ_MASK), 8'h04);
      chk(32'(irq), 32'h0000_0001);
      wr(ba(pcd_pkg::IDX_IRQ_STAT), 8'h0b);
      chk(32'(irq), 32'h0000_0001);
      rd(ba(pcd_pkg::IDX_IRQ_STAT), v);
      chk(v, 32'h0000_0004);
      wr(ba(pcd_pkg::IDX_IRQ_STAT), 8'h04);
      chk(32'(irq), 32'h0000_0000);
      $display("test interrupt done");
   endtask : t_irq

   // Main sequence
   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_loop();
      t_cable(0, 8'h06, 2'h0, 9'h1a5, 2'h0, 9'h1a5);
      t_cable(1, 8'h09, 2'h1, 9'h0ff, 2'h1, 9'h0ff);
      t_cable(0, 8'h0c, 2'h2, 9'h100, 2'h2, 9'h100);
      t_cable(1, 8'h0f, 2'h3, 9'h1ff, 2'h3, 9'h1ff);
      t_cable(0, 8'h00, 2'h0, 9'h155, 2'h3, 9'h000);
      t_neg();
      t_irq();
      finish_test();
   end
endmodule : tb
